//--- rtl/arf_pkg.sv
// Constants, field layouts and carrier types for the application register files.
package arf_pkg;
    // File sizes and index widths.
    localparam int INT_N = 128;
    localparam int FP_N = 128;
    localparam int FLAG_N = 64;
    localparam int JT_N = 8;
    localparam int IDX_W = 7;
    localparam int FLAG_IDX_W = 6;
    localparam int JT_IDX_W = 4;
    localparam int JT_SEL_W = 3;
    localparam int LANES = 8;

    // Hardwired entries and region boundaries.
    localparam logic [IDX_W-1:0] INT_ZERO_IDX = 7'h00;
    localparam logic [IDX_W-1:0] INT_STACK_BASE = 7'h20;
    localparam logic [IDX_W-1:0] FP_ZERO_IDX = 7'h00;
    localparam logic [IDX_W-1:0] FP_ONE_IDX = 7'h01;
    localparam logic [IDX_W-1:0] FP_ROT_BASE = 7'h20;
    localparam logic [FLAG_IDX_W-1:0] FLAG_TRUE_IDX = 6'h00;
    localparam logic [FLAG_IDX_W-1:0] FLAG_ROT_BASE = 6'h10;

    // Window of entries that legacy 32-bit code may reach.
    localparam logic [IDX_W-1:0] LEG_LO = 7'h08;
    localparam logic [IDX_W-1:0] LEG_HI = 7'h1f;

    // Jump-target index space: implemented, unimplemented, reserved, ignored.
    localparam logic [JT_IDX_W-1:0] JT_UNIMPL_LO = 4'h8;
    localparam logic [JT_IDX_W-1:0] JT_RSV_LO = 4'hc;
    localparam logic [JT_IDX_W-1:0] JT_IGN_LO = 4'he;
    localparam logic [1:0] JT_CLS_IMPL = 2'h0;
    localparam logic [1:0] JT_CLS_UNIMPL = 2'h1;
    localparam logic [1:0] JT_CLS_RSV = 2'h2;
    localparam logic [1:0] JT_CLS_IGN = 2'h3;
    // Low address bits of a jump target form an ignored field.
    localparam logic [63:0] JT_IGN_MASK = 64'h000000000000000f;

    // Multimedia lane size codes; every other code is undefined.
    localparam logic [2:0] MM_SZ_8 = 3'h1;
    localparam logic [2:0] MM_SZ_16 = 3'h2;
    localparam logic [2:0] MM_SZ_32 = 3'h4;

    // Floating-point register word: sign, 17-bit exponent, 64-bit significand.
    typedef struct packed {
        logic sign;
        logic [16:0] exponent;
        logic [63:0] significand;
    } arf_fp_word_t;

    localparam arf_fp_word_t FP_ZERO = '{1'b0, 17'h00000, 64'h0000000000000000};
    localparam arf_fp_word_t FP_ONE = '{1'b0, 17'h0ffff, 64'h8000000000000000};
    localparam arf_fp_word_t DEFERRED_FAULT_FP_VALUE =
        '{1'b0, 17'h1fffe, 64'h0000000000000000};

    // Integer register word with its deferred-fault tag.
    typedef struct packed {
        logic deferred_fault_tag;
        logic [63:0] data;
    } arf_int_word_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
    } arf_rd_req_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
        arf_int_word_t word;
    } arf_int_wr_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] idx;
        logic deferred;
        arf_fp_word_t value;
    } arf_fp_wr_t;

    typedef struct packed {
        logic valid;
        logic [FLAG_IDX_W-1:0] idx;
    } arf_flag_rd_t;

    typedef struct packed {
        logic valid;
        logic [FLAG_IDX_W-1:0] idx;
        logic value;
    } arf_flag_wr_t;

    typedef struct packed {
        logic valid;
        logic [JT_IDX_W-1:0] idx;
    } arf_jt_rd_t;

    typedef struct packed {
        logic valid;
        logic [JT_IDX_W-1:0] idx;
        logic [63:0] addr;
    } arf_jt_wr_t;

    // Multimedia control word: reserved field and lane size field.
    typedef struct packed {
        logic [4:0] rsv;
        logic [2:0] size;
    } arf_mm_ctl_t;

    typedef struct packed {
        logic valid;
        arf_mm_ctl_t ctl;
        logic [IDX_W-1:0] dst;
        logic [IDX_W-1:0] src_a;
        logic [IDX_W-1:0] src_b;
    } arf_mm_req_t;

    typedef struct packed {
        logic valid;
        logic static_region;
        arf_int_word_t word;
    } arf_int_rsp_t;

    typedef struct packed {
        logic valid;
        logic static_region;
        logic deferred;
        arf_fp_word_t value;
    } arf_fp_rsp_t;

    typedef struct packed {
        logic valid;
        logic static_region;
        logic value;
    } arf_flag_rsp_t;

    typedef struct packed {
        logic valid;
        logic [63:0] addr;
    } arf_jt_rsp_t;

    typedef struct packed {
        logic illegal_op;
        logic rsv_reg_field;
    } arf_fault_t;
endpackage

//--- rtl/arf_regfiles.sv
// Application register files: integer, floating-point, condition flag and jump target.
`timescale 1ns/1ps
module arf_regfiles (
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Execution mode from the core.
    input wire logic legacy_mode,
    // Integer file requests.
    input wire arf_pkg::arf_rd_req_t int_rd,
    input wire arf_pkg::arf_int_wr_t int_wr,
    input wire arf_pkg::arf_mm_req_t mm,
    // Floating-point file requests.
    input wire arf_pkg::arf_rd_req_t fp_rd,
    input wire arf_pkg::arf_fp_wr_t fp_wr,
    // Condition flag requests.
    input wire arf_pkg::arf_flag_rd_t flag_rd,
    input wire arf_pkg::arf_flag_wr_t flag_wr,
    // Jump target requests.
    input wire arf_pkg::arf_jt_rd_t jt_rd,
    input wire arf_pkg::arf_jt_wr_t jt_wr,
    // Read answers and faults.
    output arf_pkg::arf_int_rsp_t int_rsp,
    output arf_pkg::arf_fp_rsp_t fp_rsp,
    output arf_pkg::arf_flag_rsp_t flag_rsp,
    output arf_pkg::arf_jt_rsp_t jt_rsp,
    output arf_pkg::arf_fault_t fault
);
    import arf_pkg::*;

    // True when the index is reachable in the current execution mode.
    function automatic logic leg_ok(input logic leg, input logic [IDX_W-1:0] idx);
        return !leg || (idx >= LEG_LO && idx <= LEG_HI);
    endfunction

    // Classifies a jump-target index.
    function automatic logic [1:0] jt_class(input logic [JT_IDX_W-1:0] idx);
        if (idx >= JT_IGN_LO) begin
            return JT_CLS_IGN;
        end else if (idx >= JT_RSV_LO) begin
            return JT_CLS_RSV;
        end else if (idx >= JT_UNIMPL_LO) begin
            return JT_CLS_UNIMPL;
        end
        return JT_CLS_IMPL;
    endfunction

    // True when byte b opens a new lane for the given size code.
    function automatic logic lane_start(input logic [2:0] size, input logic [2:0] b);
        unique case (size)
            MM_SZ_8: return 1'b1;
            MM_SZ_16: return b[0] == 1'b0;
            default: return b[1:0] == 2'b00;
        endcase
    endfunction

    // Storage arrays.
    arf_int_word_t integer_regs_q [INT_N];
    arf_fp_word_t float_regs_q [FP_N];
    logic [FLAG_N-1:0] condition_flags_q;
    logic [63:0] jump_target_regs_q [JT_N];

    // Answer registers.
    arf_int_rsp_t int_rsp_q, int_rsp_d;
    arf_fp_rsp_t fp_rsp_q, fp_rsp_d;
    arf_flag_rsp_t flag_rsp_q, flag_rsp_d;
    arf_jt_rsp_t jt_rsp_q, jt_rsp_d;
    arf_fault_t fault_q, fault_d;

    // Integer read: entry zero is hardwired, legacy reach is limited.
    wire logic int_rd_ill = int_rd.valid && !leg_ok(legacy_mode, int_rd.idx);
    wire arf_int_word_t int_rd_word = (int_rd.idx == INT_ZERO_IDX) ? '0
        : integer_regs_q[int_rd.idx];
    wire logic int_rd_ok = int_rd.valid && !int_rd_ill;

    // Integer write: entry zero is read-only and faults.
    wire logic int_wr_ill = int_wr.valid && ((int_wr.idx == INT_ZERO_IDX)
        || !leg_ok(legacy_mode, int_wr.idx));
    wire logic int_wr_go = int_wr.valid && !int_wr_ill;

    // Multimedia control checks: reserved field and lane size value.
    wire logic mm_size_ok = (mm.ctl.size == MM_SZ_8) || (mm.ctl.size == MM_SZ_16)
        || (mm.ctl.size == MM_SZ_32);
    wire logic mm_rsv = mm.valid && ((mm.ctl.rsv != '0)
        || !mm_size_ok);
    wire logic mm_ill = mm.valid && ((mm.dst == INT_ZERO_IDX)
        || !leg_ok(legacy_mode, mm.dst) || !leg_ok(legacy_mode, mm.src_a)
        || !leg_ok(legacy_mode, mm.src_b));
    wire logic mm_go = mm.valid && !mm_rsv && !mm_ill;

    // Multimedia operands, with entry zero reading as zero.
    wire arf_int_word_t mm_a = (mm.src_a == INT_ZERO_IDX) ? '0 : integer_regs_q[mm.src_a];
    wire arf_int_word_t mm_b = (mm.src_b == INT_ZERO_IDX) ? '0 : integer_regs_q[mm.src_b];
    logic [LANES-1:0] mm_carry;
    logic [LANES-1:0] mm_cin;
    logic [63:0] mm_sum;

    // Byte adders whose carry chain is cut at every lane boundary.
    generate
        for (genvar b = 0; b < LANES; b++) begin : g_lane
            if (b == 0) begin : g_first
                assign mm_cin[b] = 1'b0;
            end else begin : g_rest
                assign mm_cin[b] = lane_start(mm.ctl.size, 3'(b)) ? 1'b0
                    : mm_carry[b-1];
            end
            assign {mm_carry[b], mm_sum[8*b+:8]} = {1'b0, mm_a.data[8*b+:8]}
                + {1'b0, mm_b.data[8*b+:8]} + {8'h00, mm_cin[b]};
        end
    endgenerate

    // A deferred tag on either source propagates to the result.
    wire arf_int_word_t mm_word = '{mm_a.deferred_fault_tag | mm_b.deferred_fault_tag, mm_sum};

    // Floating-point read: entries zero and one are constants.
    wire logic fp_rd_ill = fp_rd.valid && !leg_ok(legacy_mode, fp_rd.idx);
    wire arf_fp_word_t fp_rd_val = (fp_rd.idx == FP_ZERO_IDX) ? FP_ZERO
        : (fp_rd.idx == FP_ONE_IDX) ? FP_ONE
        : float_regs_q[fp_rd.idx];
    wire logic fp_rd_ok = fp_rd.valid && !fp_rd_ill;

    // Floating-point write: the constant entries fault as destinations.
    wire logic fp_wr_ill = fp_wr.valid && ((fp_wr.idx <= FP_ONE_IDX)
        || !leg_ok(legacy_mode, fp_wr.idx));
    wire logic fp_wr_go = fp_wr.valid && !fp_wr_ill;
    wire arf_fp_word_t fp_wr_val = fp_wr.deferred ? DEFERRED_FAULT_FP_VALUE
        : fp_wr.value;

    // Condition flags are native-only state.
    wire logic flag_rd_ill = flag_rd.valid && legacy_mode;
    wire logic flag_rd_val = (flag_rd.idx == FLAG_TRUE_IDX) ? 1'b1
        : condition_flags_q[flag_rd.idx];
    wire logic flag_wr_ill = flag_wr.valid && legacy_mode;
    wire logic flag_wr_go = flag_wr.valid && !flag_wr_ill
        && (flag_wr.idx != FLAG_TRUE_IDX);

    // Jump targets: index class decides between data, zero and faults.
    wire logic [1:0] jt_rd_cls = jt_class(jt_rd.idx);
    wire logic [1:0] jt_wr_cls = jt_class(jt_wr.idx);
    wire logic jt_rd_rsv = jt_rd.valid && !legacy_mode
        && (jt_rd_cls == JT_CLS_UNIMPL);
    wire logic jt_rd_ill = jt_rd.valid && (legacy_mode
        || (jt_rd_cls == JT_CLS_RSV));
    wire logic jt_wr_rsv = jt_wr.valid && !legacy_mode
        && (jt_wr_cls == JT_CLS_UNIMPL);
    wire logic jt_wr_ill = jt_wr.valid && (legacy_mode
        || (jt_wr_cls == JT_CLS_RSV));
    wire logic jt_wr_go = jt_wr.valid && !jt_wr_ill && !jt_wr_rsv
        && (jt_wr_cls == JT_CLS_IMPL);
    wire logic [JT_SEL_W-1:0] jt_rd_sel = jt_rd.idx[JT_SEL_W-1:0];
    wire logic [JT_SEL_W-1:0] jt_wr_sel = jt_wr.idx[JT_SEL_W-1:0];
    wire logic [63:0] jt_rd_val = (jt_rd_cls == JT_CLS_IMPL)
        ? jump_target_regs_q[jt_rd_sel] : '0;

    // Next answers; a faulting read returns no data.
    always_comb begin
        int_rsp_d = '0;
        fp_rsp_d = '0;
        flag_rsp_d = '0;
        jt_rsp_d = '0;
        if (int_rd_ok) begin
            int_rsp_d = '{1'b1, int_rd.idx < INT_STACK_BASE, int_rd_word};
        end
        if (fp_rd_ok) begin
            fp_rsp_d = '{1'b1, fp_rd.idx < FP_ROT_BASE,
                fp_rd_val == DEFERRED_FAULT_FP_VALUE, fp_rd_val};
        end
        if (flag_rd.valid && !flag_rd_ill) begin
            flag_rsp_d = '{1'b1, flag_rd.idx < FLAG_ROT_BASE, flag_rd_val};
        end
        if (jt_rd.valid && !jt_rd_ill && !jt_rd_rsv) begin
            jt_rsp_d = '{1'b1, jt_rd_val};
        end
    end

    // Faults from all ports merge into two one-cycle pulses.
    assign fault_d.illegal_op = int_rd_ill || int_wr_ill || mm_ill || fp_rd_ill
        || fp_wr_ill || flag_rd_ill || flag_wr_ill || jt_rd_ill || jt_wr_ill;
    assign fault_d.rsv_reg_field = mm_rsv || jt_rd_rsv || jt_wr_rsv;

    // Integer file; the direct write port wins over a multimedia result.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < INT_N; i++) begin
                integer_regs_q[i] <= '0;
            end
        end else if (int_wr_go) begin
            integer_regs_q[int_wr.idx] <= int_wr.word;
        end else if (mm_go) begin
            integer_regs_q[mm.dst] <= mm_word;
        end
    end

    // Floating-point file.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < FP_N; i++) begin
                float_regs_q[i] <= FP_ZERO;
            end
        end else if (fp_wr_go) begin
            float_regs_q[fp_wr.idx] <= fp_wr_val;
        end
    end

    // Condition flags.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            condition_flags_q <= '0;
        end else if (flag_wr_go) begin
            condition_flags_q[flag_wr.idx] <= flag_wr.value;
        end
    end

    // Jump targets; the ignored low field is dropped on write.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < JT_N; i++) begin
                jump_target_regs_q[i] <= '0;
            end
        end else if (jt_wr_go) begin
            jump_target_regs_q[jt_wr_sel] <= jt_wr.addr & ~JT_IGN_MASK;
        end
    end

    // Registered answers and fault pulses.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            int_rsp_q <= '0;
            fp_rsp_q <= '0;
            flag_rsp_q <= '0;
            jt_rsp_q <= '0;
            fault_q <= '0;
        end else begin
            int_rsp_q <= int_rsp_d;
            fp_rsp_q <= fp_rsp_d;
            flag_rsp_q <= flag_rsp_d;
            jt_rsp_q <= jt_rsp_d;
            fault_q <= fault_d;
        end
    end

    assign int_rsp = int_rsp_q;
    assign fp_rsp = fp_rsp_q;
    assign flag_rsp = flag_rsp_q;
    assign jt_rsp = jt_rsp_q;
    assign fault = fault_q;
endmodule // arf_regfiles

//--- verification/arf_regfiles_props.sv
// Concurrent checks on the ports of the application register files.
`timescale 1ns/1ps
module arf_regfiles_props (
    // Clock and reset.
    input wire logic clock,
    input wire logic arst_n,
    // Requests.
    input wire logic legacy_mode,
    input wire arf_pkg::arf_rd_req_t int_rd,
    input wire arf_pkg::arf_int_wr_t int_wr,
    input wire arf_pkg::arf_mm_req_t mm,
    input wire arf_pkg::arf_rd_req_t fp_rd,
    input wire arf_pkg::arf_fp_wr_t fp_wr,
    input wire arf_pkg::arf_flag_rd_t flag_rd,
    input wire arf_pkg::arf_flag_wr_t flag_wr,
    input wire arf_pkg::arf_jt_rd_t jt_rd,
    input wire arf_pkg::arf_jt_wr_t jt_wr,
    // Answers and faults.
    input wire arf_pkg::arf_int_rsp_t int_rsp,
    input wire arf_pkg::arf_fp_rsp_t fp_rsp,
    input wire arf_pkg::arf_flag_rsp_t flag_rsp,
    input wire arf_pkg::arf_jt_rsp_t jt_rsp,
    input wire arf_pkg::arf_fault_t fault
);
    import arf_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // Hardwired entries answer their constants one cycle after the request.
    int_zero_a: assert property (int_rd.valid && int_rd.idx == INT_ZERO_IDX
        && !legacy_mode |=> int_rsp.valid && int_rsp.word == '0)
        else $error("integer entry zero not zero");
    int_wr_zero_a: assert property (int_wr.valid && int_wr.idx == INT_ZERO_IDX
        |=> fault.illegal_op) else $error("integer entry zero write did not fault");
    int_static_a: assert property (int_rd.valid && !legacy_mode
        |=> int_rsp.static_region == ($past(int_rd.idx) < INT_STACK_BASE))
        else $error("integer static region flag wrong");
    fp_one_a: assert property (fp_rd.valid && fp_rd.idx == FP_ONE_IDX && !legacy_mode
        |=> fp_rsp.valid && fp_rsp.value == FP_ONE) else $error("float entry one not one");
    fp_dst_a: assert property (fp_wr.valid && fp_wr.idx <= FP_ONE_IDX
        |=> fault.illegal_op) else $error("float constant write did not fault");
    flag_true_a: assert property (flag_rd.valid && flag_rd.idx == FLAG_TRUE_IDX
        && !legacy_mode |=> flag_rsp.valid && flag_rsp.value) else $error("flag zero not one");
    jt_rsv_a: assert property (jt_rd.valid && jt_rd.idx >= JT_RSV_LO
        && jt_rd.idx < JT_IGN_LO |=> fault.illegal_op && !jt_rsp.valid)
        else $error("reserved jump target");
    // Legacy code gets an illegal-operation fault instead, so it is left out here.
    jt_unimpl_a: assert property (jt_rd.valid && jt_rd.idx >= JT_UNIMPL_LO
        && jt_rd.idx < JT_RSV_LO && !legacy_mode |=> fault.rsv_reg_field)
        else $error("unimplemented target");
    jt_ignored_a: assert property (jt_rd.valid && jt_rd.idx >= JT_IGN_LO && !legacy_mode
        |=> jt_rsp.valid && jt_rsp.addr == '0) else $error("ignored jump target not zero");
    jt_field_a: assert property (jt_rsp.valid |-> (jt_rsp.addr & JT_IGN_MASK) == '0)
        else $error("ignored address bits not zero");
    mm_rsv_a: assert property (mm.valid && mm.ctl.rsv != '0 |=> fault.rsv_reg_field)
        else $error("reserved control field did not fault");
    legacy_reach_a: assert property (legacy_mode && int_rd.valid
        && (int_rd.idx < LEG_LO || int_rd.idx > LEG_HI) |=> fault.illegal_op && !int_rsp.valid)
        else $error("legacy reach beyond its window");

    // Main scenarios seen at least once.
    cover property (int_wr.valid && int_wr.idx == INT_ZERO_IDX);
    cover property (mm.valid && mm.ctl.size == MM_SZ_32);
    cover property (legacy_mode && int_rd.valid);
endmodule // arf_regfiles_props

//--- verification/arf_exec_units.sv
// Behavioural model of the execution units that issue register file requests.
`timescale 1ns/1ps
package arf_tb_pkg;
    // All request ports of the register files bundled together.
    typedef struct packed {
        arf_pkg::arf_rd_req_t int_rd;
        arf_pkg::arf_int_wr_t int_wr;
        arf_pkg::arf_mm_req_t mm;
        arf_pkg::arf_rd_req_t fp_rd;
        arf_pkg::arf_fp_wr_t fp_wr;
        arf_pkg::arf_flag_rd_t flag_rd;
        arf_pkg::arf_flag_wr_t flag_wr;
        arf_pkg::arf_jt_rd_t jt_rd;
        arf_pkg::arf_jt_wr_t jt_wr;
    } arf_req_bundle_t;
endpackage

module arf_exec_units (
    // Core clock.
    input wire logic clock,
    // Requests towards the register files.
    output arf_tb_pkg::arf_req_bundle_t req
);
    import arf_tb_pkg::*;
    arf_req_bundle_t stage;

    // Staged requests go out for exactly one cycle, just after an edge.
    // Reserved control fields carry zero unless a scenario stages otherwise.
    task automatic fire();
        @(posedge clock);
        #1 req = stage;
        @(posedge clock);
        #1 req = '0;
        stage = '0;
    endtask

    // Idle at time zero.
    initial begin
        req = '0;
        stage = '0;
    end
endmodule // arf_exec_units

//--- verification/tb_application_register_files.sv
// Self-checking testbench for the application register files.
`timescale 1ns/1ps
module tb_application_register_files;
    import arf_pkg::*;
    logic clock;
    logic arst_n;
    logic legacy_mode;
    arf_tb_pkg::arf_req_bundle_t req;
    arf_int_rsp_t int_rsp;
    arf_fp_rsp_t fp_rsp;
    arf_flag_rsp_t flag_rsp;
    arf_jt_rsp_t jt_rsp;
    arf_fault_t fault;
    int num_errors = 0;
    int cmp_count = 0;
    localparam logic [63:0] OP_A = 64'h80ff_7fff_ffff_0001;
    localparam logic [63:0] OP_B = 64'h8001_8001_0001_ffff;
    localparam arf_fp_word_t FP_V = '{1'b1, 17'h1003f, 64'hc000_0000_0000_0000};

    // Partner and design.
    arf_exec_units p (.clock(clock), .req(req));
    arf_regfiles DUT (.clock(clock), .arst_n(arst_n), .legacy_mode(legacy_mode),
        .int_rd(req.int_rd), .int_wr(req.int_wr), .mm(req.mm), .fp_rd(req.fp_rd),
        .fp_wr(req.fp_wr), .flag_rd(req.flag_rd), .flag_wr(req.flag_wr), .jt_rd(req.jt_rd),
        .jt_wr(req.jt_wr), .int_rsp(int_rsp), .fp_rsp(fp_rsp), .flag_rsp(flag_rsp),
        .jt_rsp(jt_rsp), .fault(fault));

    // Core clock of 50 MHz.
    always #10 clock = ~clock;

    // Compares one result and counts it.
    task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Lane-wise sum with the carry cut at every lane boundary.
    function automatic logic [63:0] ladd(input logic [63:0] a, input logic [63:0] b, input int w);
        logic c;
        c = 1'b0;
        for (int k = 0; k < 64; k++) begin
            if (k % w == 0) begin
                c = 1'b0;
            end
            ladd[k] = a[k] ^ b[k] ^ c;
            c = (a[k] & b[k]) | (c & (a[k] ^ b[k]));
        end
    endfunction

    // Integer file: storage, regions, entry zero, read during write.
    task automatic t_int();
        p.stage.int_wr = '{1'b1, 7'h05, '{1'b1, OP_A}};
        p.fire();
        p.stage.int_rd = '{1'b1, 7'h05};
        p.fire();
        chk("int5", {3'b111, OP_A}, int_rsp);
        p.stage.int_wr = '{1'b1, 7'h7f, '{1'b0, OP_B}};
        p.stage.int_rd = '{1'b1, 7'h7f};
        p.fire();
        chk("int127 old", {3'b100, 64'h0}, int_rsp);
        p.stage.int_rd = '{1'b1, 7'h7f};
        p.fire();
        chk("int127", {3'b100, OP_B}, int_rsp);
        p.stage.int_wr = '{1'b1, INT_ZERO_IDX, '{1'b1, OP_A}};
        p.fire();
        chk("int0 write", 2'b10, fault);
        p.stage.int_rd = '{1'b1, INT_ZERO_IDX};
        p.fire();
        chk("int0", {3'b110, 64'h0}, int_rsp);
        $display("TB: test int done");
    endtask

    // Float file: constants, destination faults, deferred encoding.
    task automatic t_fp();
        p.stage.fp_rd = '{1'b1, FP_ONE_IDX};
        p.fire();
        chk("fp1", {3'b110, FP_ONE}, fp_rsp);
        p.stage.fp_wr = '{1'b1, FP_ZERO_IDX, 1'b0, FP_V};
        p.stage.fp_rd = '{1'b1, FP_ZERO_IDX};
        p.fire();
        chk("fp0 write", 2'b10, fault);
        chk("fp0", {3'b110, FP_ZERO}, fp_rsp);
        p.stage.fp_wr = '{1'b1, 7'h28, 1'b1, DEFERRED_FAULT_FP_VALUE};
        p.fire();
        p.stage.fp_rd = '{1'b1, 7'h28};
        p.fire();
        chk("fp40", {3'b101, DEFERRED_FAULT_FP_VALUE}, fp_rsp);
        p.stage.fp_wr = '{1'b1, 7'h1f, 1'b0, FP_V};
        p.fire();
        p.stage.fp_rd = '{1'b1, 7'h1f};
        p.fire();
        chk("fp31", {3'b110, FP_V}, fp_rsp);
        $display("TB: test fp done");
    endtask

    // Condition flags: storage, regions, the always-true flag.
    task automatic t_flag();
        p.stage.flag_wr = '{1'b1, 6'h14, 1'b1};
        p.fire();
        p.stage.flag_rd = '{1'b1, 6'h14};
        p.fire();
        chk("flag20", 3'b101, flag_rsp);
        p.stage.flag_wr = '{1'b1, FLAG_TRUE_IDX, 1'b0};
        p.stage.flag_rd = '{1'b1, 6'h0f};
        p.fire();
        chk("flag0 write", 2'b00, fault);
        chk("flag15", 3'b110, flag_rsp);
        p.stage.flag_rd = '{1'b1, FLAG_TRUE_IDX};
        p.fire();
        chk("flag0", 3'b111, flag_rsp);
        $display("TB: test flag done");
    endtask

    // Jump targets: ignored field, unimplemented, reserved and ignored entries.
    task automatic t_jt();
        p.stage.jt_wr = '{1'b1, 4'h7, 64'h1234_5678_9abc_def5};
        p.fire();
        p.stage.jt_rd = '{1'b1, 4'h7};
        p.fire();
        chk("jt7", {1'b1, 64'h1234_5678_9abc_def0}, jt_rsp);
        p.stage.jt_rd = '{1'b1, 4'h9};
        p.fire();
        chk("jt9 fault", 2'b01, fault);
        p.stage.jt_wr = '{1'b1, 4'hc, OP_A};
        p.fire();
        chk("jt12 fault", 2'b10, fault);
        p.stage.jt_rd = '{1'b1, 4'hd};
        p.fire();
        chk("jt13 fault", 2'b10, fault);
        chk("jt13 data", 65'h0, jt_rsp);
        p.stage.jt_wr = '{1'b1, 4'hf, OP_A};
        p.fire();
        chk("jt15 write", 2'b00, fault);
        p.stage.jt_rd = '{1'b1, 4'hf};
        p.fire();
        chk("jt15", {1'b1, 64'h0}, jt_rsp);
        $display("TB: test jt done");
    endtask

    // Multimedia lanes for every size code, then bad control words.
    task automatic t_mm();
        p.stage.int_wr = '{1'b1, 7'h0a, '{1'b0, OP_A}};
        p.fire();
        p.stage.int_wr = '{1'b1, 7'h0b, '{1'b1, OP_B}};
        p.fire();
        for (int s = 0; s < 3; s++) begin
            p.stage.mm = '{1'b1, '{5'h00, 3'(1 << s)}, 7'(12 + s), 7'h0a, 7'h0b};
            p.fire();
            p.stage.int_rd = '{1'b1, 7'(12 + s)};
            p.fire();
            chk("mm lanes", {3'b111, ladd(OP_A, OP_B, 8 << s)}, int_rsp);
        end
        p.stage.mm = '{1'b1, '{5'h01, MM_SZ_8}, 7'h0e, 7'h0a, 7'h0b};
        p.fire();
        chk("mm rsv", 2'b01, fault);
        p.stage.mm = '{1'b1, '{5'h00, 3'h3}, 7'h0c, 7'h0a, 7'h0b};
        p.fire();
        chk("mm size", 2'b01, fault);
        p.stage.int_rd = '{1'b1, 7'h0c};
        p.fire();
        chk("mm kept", {3'b111, ladd(OP_A, OP_B, 8)}, int_rsp);
        $display("TB: test mm done");
    endtask

    // Legacy mode: its window is reachable, native-only state is not.
    task automatic t_leg();
        legacy_mode = 1'b1;
        p.stage.int_wr = '{1'b1, LEG_LO, '{1'b0, OP_B}};
        p.fire();
        p.stage.int_rd = '{1'b1, LEG_LO};
        p.stage.fp_rd = '{1'b1, LEG_HI};
        p.fire();
        chk("leg int8", {3'b110, OP_B}, int_rsp);
        chk("leg fp31", {3'b110, FP_V}, fp_rsp);
        p.stage.int_rd = '{1'b1, 7'h20};
        p.fire();
        chk("leg int32", 2'b10, fault);
        p.stage.flag_rd = '{1'b1, 6'h01};
        p.fire();
        chk("leg flag", 2'b10, fault);
        legacy_mode = 1'b0;
        $display("TB: test legacy done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("TB: %0d compares, %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Reset for ten cycles, then the scenarios in turn.
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        legacy_mode = 1'b0;
        repeat (10) @(posedge clock);
        #1 arst_n = 1'b1;
        t_int();
        t_fp();
        t_flag();
        t_jt();
        t_mm();
        t_leg();
        close_out();
    end

    // Watchdog well beyond the hundred or so cycles the scenarios need.
    initial begin
        #40000;
        num_errors++;
        close_out();
    end
endmodule // tb_application_register_files

bind arf_regfiles arf_regfiles_props u_props (.clock(clock), .arst_n(arst_n),
    .legacy_mode(legacy_mode), .int_rd(int_rd), .int_wr(int_wr), .mm(mm), .fp_rd(fp_rd),
    .fp_wr(fp_wr), .flag_rd(flag_rd), .flag_wr(flag_wr), .jt_rd(jt_rd), .jt_wr(jt_wr),
    .int_rsp(int_rsp), .fp_rsp(fp_rsp), .flag_rsp(flag_rsp), .jt_rsp(jt_rsp), .fault(fault));
